// >>> hdl/bps_pkg.sv
// constants shared by the breaker position and command supervision block
// assumes a single 10 MHz clock and an AHB-Lite register port
package bps_pkg;
   // ==========================================
   // timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TICK_MS = 10;
   localparam int unsigned TICK_CYCLES_C = CLK_HZ / 1000 * TICK_MS;
   localparam int TIME_W = 14;
   localparam logic [TIME_W-1:0] TIME_MIN = 14'h0001;
   localparam logic [TIME_W-1:0] TIME_MAX = 14'h2710;
   localparam logic [TIME_W-1:0] MOVE_RST = 14'h000A;
   localparam logic [TIME_W-1:0] DIST_RST = 14'h000A;
   // ==========================================
   // position codes
   typedef logic [1:0] bps_pos_t;
   localparam bps_pos_t POS_INDET = 2'h0;
   localparam bps_pos_t POS_OPEN = 2'h1;
   localparam bps_pos_t POS_CLOSED = 2'h2;
   localparam bps_pos_t POS_DISTURB = 2'h3;
   // ==========================================
   // register map
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MOVE = 8'h04;
   localparam logic [7:0] OFS_DIST = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_EVENT = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam int CTRL_SINGLE = 0;
   localparam logic CTRL_RST = 1'b0;
   // event bits, shared by event and mask registers
   localparam int EV_W = 6;
   localparam int EV_SUCCESS = 0;
   localparam int EV_DISTURB = 1;
   localparam int EV_TRIP = 2;
   localparam int EV_REDUND = 3;
   localparam int EV_CDO = 4;
   localparam int EV_NREADY = 5;
   localparam logic [EV_W-1:0] MASK_RST = 6'h00;
   // status bits
   localparam int ST_POS = 0;
   localparam int ST_CLOSED = 2;
   localparam int ST_OPEN = 3;
   localparam int ST_INDET = 4;
   localparam int ST_DISTURB = 5;
   localparam int ST_NOTCL = 6;
   localparam int ST_SINGLE = 7;
   localparam int ST_READY = 8;
   localparam int ST_REMOVED = 9;
   localparam int ST_CLOCK = 10;
   localparam int ST_OLOCK = 11;
   localparam int ST_CLOSING = 12;
   localparam int ST_OPENING = 13;
   // ==========================================
   // AHB-Lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
   typedef enum logic [1:0] {CMD_IDLE, CMD_CLOSING, CMD_OPENING} bps_cmd_e;
endpackage

// >>> hdl/bps_timer.sv
// interval timer counting 10 ms ticks while run is high
// assumes limit is held stable during a run
`timescale 1ns/1ns
module bps_timer import bps_pkg::*; #(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_C
) (
   input wire logic clock,
   input wire logic rst_sync_n,
   bps_tmr_if.timer tif
);
   logic [16:0] div_q, div_d;
   logic [TIME_W-1:0] cnt_q, cnt_d;
   logic exp_q, exp_d;

   // ==========================================
   // divider and tick counter
   always_comb begin
      div_d = div_q;
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (!tif.run) begin
         // restart from zero so each run gets its full time
         div_d = '0;
         cnt_d = '0;
      end else begin
         if (div_q == 17'(TICK_CYCLES - 1)) begin
            div_d = '0;
            if (cnt_q != TIME_MAX) begin
               cnt_d = cnt_q + 14'h0001;
            end
         end else begin
            div_d = div_q + 17'h00001;
         end
         exp_d = (cnt_d >= tif.limit);
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         div_q <= '0;
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         div_q <= div_d;
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign tif.expired = exp_q;
endmodule

// >>> hdl/bps_tmr_if.sv
// timer request and expiry between the supervision logic and a timer
// assumes both ends share the block clock
`timescale 1ns/1ns
interface bps_tmr_if;
   import bps_pkg::*;
   logic run;
   logic [TIME_W-1:0] limit;
   logic expired;
   modport user (output run, output limit, input expired);
   modport timer (input run, input limit, output expired);
endinterface

// >>> hdl/bps_top.sv
// breaker position decode, interlocks and command execution supervision
// assumes synchronous pins and a single AHB-Lite master at 10 MHz
//
// Notes on behaviour
// - position code: 0 indeterminate, 1 open, 2 closed, 3 disturbed
// - contradicting contacts become disturbed only after the supervision timer
// - closed, open, indeterminate and not-closed flags match the position code
// - single-contact wiring is flagged; no indeterminate or disturbed then
// - close lock flag set when any close lock input is active
// - open lock flag set when any open lock input is active
// - external close and open requests start breaker operations
// - success pulse when the breaker reaches the requested position
// - failed-disturbed flag when a command ends in disturbed position
// - commands refused while a trip is pending, with trip-block flag
// - command toward the present position raises redundant direction flag
// - close request while open pending raises close-during-open flag
// - request while breaker not ready raises not-ready flag
// - ready and removed flags follow their inputs
// - move time settable 0.01 to 100.00 s, default 0.1 s
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module bps_top import bps_pkg::*; #(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_C
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic closed_contact_in,
   input wire logic open_contact_in,
   input wire logic breaker_ready_in,
   input wire logic breaker_removed_in,
   input wire logic trip_pending_in,
   input wire logic close_lock_in_1,
   input wire logic close_lock_in_2,
   input wire logic close_lock_in_3,
   input wire logic open_lock_in_1,
   input wire logic open_lock_in_2,
   input wire logic open_lock_in_3,
   input wire logic ext_close_request_in,
   input wire logic ext_open_request_in,
   output logic close_cmd_out,
   output logic open_cmd_out,
   output bps_pos_t pos_code,
   output logic pos_closed,
   output logic pos_open,
   output logic pos_indeterminate,
   output logic pos_disturbed,
   output logic pos_not_closed,
   output logic single_contact_flag,
   output logic ready_flag,
   output logic removed_flag,
   output logic close_lock_flag,
   output logic open_lock_flag,
   output logic sup_cmd_success,
   output logic sup_cmd_disturbed,
   output logic sup_cmd_trip_block,
   output logic sup_redundant_direction,
   output logic sup_close_during_open,
   output logic sup_not_ready,
   output logic irq
);
   // ==========================================
   // reset release
   logic rst_m_q, rst_sync_n;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_m_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_sync_n <= rst_m_q;
      end
   end

   function automatic logic [TIME_W-1:0] clamp_time(input logic [31:0] v);
      if (v[31:TIME_W] != '0 || v[TIME_W-1:0] > TIME_MAX) begin
         return TIME_MAX;
      end
      if (v[TIME_W-1:0] < TIME_MIN) begin
         return TIME_MIN;
      end
      return v[TIME_W-1:0];
   endfunction

   // ==========================================
   // timers
   bps_tmr_if dist_tif ();
   bps_tmr_if move_tif ();
   bps_timer #(.TICK_CYCLES(TICK_CYCLES)) u_dist_timer (
      .clock(clock),
      .rst_sync_n(rst_sync_n),
      .tif(dist_tif)
   );
   bps_timer #(.TICK_CYCLES(TICK_CYCLES)) u_move_timer (
      .clock(clock),
      .rst_sync_n(rst_sync_n),
      .tif(move_tif)
   );

   // ==========================================
   // configuration registers
   logic single_q, single_d;
   logic [TIME_W-1:0] move_q, move_d, dist_q, dist_d;
   logic [EV_W-1:0] mask_q, mask_d;
   logic wr_q, wr_d;
   logic [7:0] wadr_q, wadr_d;

   always_comb begin
      single_d = single_q;
      move_d = move_q;
      dist_d = dist_q;
      mask_d = mask_q;
      wr_d = hready & hsel & (htrans == HTRANS_NONSEQ) & hwrite & (haddr[31:8] == '0);
      wadr_d = {haddr[7:2], 2'h0};
      if (wr_q) begin
         unique case (wadr_q)
            OFS_CTRL: single_d = hwdata[CTRL_SINGLE];
            OFS_MOVE: move_d = clamp_time(hwdata);
            OFS_DIST: dist_d = clamp_time(hwdata);
            OFS_MASK: mask_d = hwdata[EV_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         single_q <= CTRL_RST;
         move_q <= MOVE_RST;
         dist_q <= DIST_RST;
         mask_q <= MASK_RST;
         wr_q <= 1'b0;
         wadr_q <= 8'h00;
      end else begin
         single_q <= single_d;
         move_q <= move_d;
         dist_q <= dist_d;
         mask_q <= mask_d;
         wr_q <= wr_d;
         wadr_q <= wadr_d;
      end
   end

   // ==========================================
   // position decode
   bps_pos_t pos_d;
   logic clock_d, olock_d;
   assign dist_tif.run = closed_contact_in & open_contact_in & ~single_q;
   assign dist_tif.limit = dist_q;

   always_comb begin
      clock_d = close_lock_in_1 | close_lock_in_2 | close_lock_in_3;
      olock_d = open_lock_in_1 | open_lock_in_2 | open_lock_in_3;
      if (single_q) begin
         // one contact cannot show a contradiction
         pos_d = closed_contact_in ? POS_CLOSED : POS_OPEN;
      end else if (closed_contact_in && !open_contact_in) begin
         pos_d = POS_CLOSED;
      end else if (!closed_contact_in && open_contact_in) begin
         pos_d = POS_OPEN;
      end else if (closed_contact_in && dist_tif.expired) begin
         pos_d = POS_DISTURB;
      end else begin
         pos_d = POS_INDET;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pos_code <= POS_INDET;
         pos_closed <= 1'b0;
         pos_open <= 1'b0;
         pos_indeterminate <= 1'b1;
         pos_disturbed <= 1'b0;
         pos_not_closed <= 1'b1;
         single_contact_flag <= 1'b0;
         ready_flag <= 1'b0;
         removed_flag <= 1'b0;
         close_lock_flag <= 1'b0;
         open_lock_flag <= 1'b0;
      end else begin
         pos_code <= pos_d;
         pos_closed <= (pos_d == POS_CLOSED);
         pos_open <= (pos_d == POS_OPEN);
         pos_indeterminate <= (pos_d == POS_INDET);
         pos_disturbed <= (pos_d == POS_DISTURB);
         pos_not_closed <= (pos_d != POS_CLOSED);
         single_contact_flag <= single_q;
         ready_flag <= breaker_ready_in;
         removed_flag <= breaker_removed_in;
         close_lock_flag <= clock_d;
         open_lock_flag <= olock_d;
      end
   end

   // ==========================================
   // command execution supervision
   bps_cmd_e cmd_q, cmd_d;
   logic creq_q, oreq_q;
   logic [EV_W-1:0] ev_set;
   logic close_edge, open_edge;
   assign close_edge = ext_close_request_in & ~creq_q;
   assign open_edge = ext_open_request_in & ~oreq_q;
   assign move_tif.run = (cmd_q != CMD_IDLE);
   assign move_tif.limit = move_q;

   always_comb begin
      cmd_d = cmd_q;
      ev_set = '0;
      unique case (cmd_q)
         CMD_IDLE: begin
            if (close_edge || open_edge) begin
               if (trip_pending_in) begin
                  ev_set[EV_TRIP] = 1'b1;
               end else if (!breaker_ready_in) begin
                  ev_set[EV_NREADY] = 1'b1;
               end else if (close_edge && pos_code == POS_CLOSED) begin
                  ev_set[EV_REDUND] = 1'b1;
               end else if (open_edge && !close_edge && pos_code == POS_OPEN) begin
                  ev_set[EV_REDUND] = 1'b1;
               end else if (close_edge && !clock_d) begin
                  cmd_d = CMD_CLOSING;
               end else if (open_edge && !close_edge && !olock_d) begin
                  cmd_d = CMD_OPENING;
               end
            end
         end
         CMD_CLOSING, CMD_OPENING: begin
            if (close_edge && cmd_q == CMD_OPENING) begin
               ev_set[EV_CDO] = 1'b1;
            end
            if (trip_pending_in) begin
               // a trip overrides the running operation
               ev_set[EV_TRIP] = 1'b1;
               cmd_d = CMD_IDLE;
            end else if (pos_code == (cmd_q == CMD_CLOSING ? POS_CLOSED : POS_OPEN)) begin
               ev_set[EV_SUCCESS] = 1'b1;
               cmd_d = CMD_IDLE;
            end else if (pos_code == POS_DISTURB) begin
               ev_set[EV_DISTURB] = 1'b1;
               cmd_d = CMD_IDLE;
            end else if (move_tif.expired) begin
               // move time ran out short of the target
               cmd_d = CMD_IDLE;
            end
         end
         default: cmd_d = CMD_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmd_q <= CMD_IDLE;
         creq_q <= 1'b0;
         oreq_q <= 1'b0;
         close_cmd_out <= 1'b0;
         open_cmd_out <= 1'b0;
         sup_cmd_success <= 1'b0;
         sup_cmd_disturbed <= 1'b0;
         sup_cmd_trip_block <= 1'b0;
         sup_redundant_direction <= 1'b0;
         sup_close_during_open <= 1'b0;
         sup_not_ready <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         creq_q <= ext_close_request_in;
         oreq_q <= ext_open_request_in;
         close_cmd_out <= (cmd_d == CMD_CLOSING);
         open_cmd_out <= (cmd_d == CMD_OPENING);
         sup_cmd_success <= ev_set[EV_SUCCESS];
         sup_cmd_disturbed <= ev_set[EV_DISTURB];
         sup_cmd_trip_block <= ev_set[EV_TRIP];
         sup_redundant_direction <= ev_set[EV_REDUND];
         sup_close_during_open <= ev_set[EV_CDO];
         sup_not_ready <= ev_set[EV_NREADY];
      end
   end

   // ==========================================
   // bus read side and events
   logic [EV_W-1:0] ev_q, ev_d;
   logic [31:0] rdata_d;
   logic rd_ok;
   logic [31:0] stat;

   always_comb begin
      stat = '0;
      stat[ST_POS+1:ST_POS] = pos_code;
      stat[ST_CLOSED] = pos_closed;
      stat[ST_OPEN] = pos_open;
      stat[ST_INDET] = pos_indeterminate;
      stat[ST_DISTURB] = pos_disturbed;
      stat[ST_NOTCL] = pos_not_closed;
      stat[ST_SINGLE] = single_contact_flag;
      stat[ST_READY] = ready_flag;
      stat[ST_REMOVED] = removed_flag;
      stat[ST_CLOCK] = close_lock_flag;
      stat[ST_OLOCK] = open_lock_flag;
      stat[ST_CLOSING] = (cmd_q == CMD_CLOSING);
      stat[ST_OPENING] = (cmd_q == CMD_OPENING);
      rd_ok = hready & hsel & (htrans == HTRANS_NONSEQ) & ~hwrite & (haddr[31:8] == '0);
      rdata_d = '0;
      ev_d = ev_q;
      if (rd_ok) begin
         unique case ({haddr[7:2], 2'h0})
            OFS_CTRL: rdata_d[CTRL_SINGLE] = single_q;
            OFS_MOVE: rdata_d[TIME_W-1:0] = move_q;
            OFS_DIST: rdata_d[TIME_W-1:0] = dist_q;
            OFS_STAT: rdata_d = stat;
            OFS_EVENT: begin
               rdata_d[EV_W-1:0] = ev_q;
               ev_d = '0;
            end
            OFS_MASK: rdata_d[EV_W-1:0] = mask_q;
            default: ;
         endcase
      end
      // an event in the clearing cycle survives
      ev_d = ev_d | ev_set;
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ev_q <= '0;
         hrdata <= '0;
         irq <= 1'b0;
         hreadyout <= 1'b0;
         hresp <= HRESP_OKAY;
      end else begin
         ev_q <= ev_d;
         hrdata <= rdata_d;
         irq <= |(ev_d & mask_q);
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end
endmodule

// >>> test/bps_breaker_model.sv
// behavioural breaker whose auxiliary contacts follow the switching commands
// assumes the bench may freeze travel or load a contact pair directly
`timescale 1ns/1ns
module bps_breaker_model (
   input wire logic clock,
   input wire logic close_cmd,
   input wire logic open_cmd,
   input wire logic stuck,
   input wire logic set_en,
   input wire logic [1:0] set_val,
   output logic closed_contact,
   output logic open_contact
);
   int travel;
   initial begin
      closed_contact = 1'b0;
      open_contact = 1'b1;
      travel = 0;
   end
   // ==========================================
   // contact travel
   always @(posedge clock) begin
      if (set_en) begin
         {closed_contact, open_contact} <= set_val;
      end else if ((close_cmd || open_cmd) && !stuck) begin
         travel <= travel + 1;
         if (travel == 1) begin
            // both contacts apart mid travel, as a real pole does
            {closed_contact, open_contact} <= 2'h0;
         end else if (travel == 3) begin
            closed_contact <= close_cmd;
            open_contact <= !close_cmd;
         end
      end else begin
         travel <= 0;
      end
   end
endmodule

// >>> test/bps_top_sva.sv
// assertions on the breaker supervision block, bound to every bps_top
// assumes flags one clock behind their pins and requests taken on rising edges
`timescale 1ns/1ns
module bps_top_sva import bps_pkg::*; #(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_C
) (
   input logic clock,
   input logic rst_n,
   input logic closed_contact_in,
   input logic open_contact_in,
   input logic breaker_ready_in,
   input logic breaker_removed_in,
   input logic trip_pending_in,
   input logic close_lock_in_1,
   input logic close_lock_in_2,
   input logic close_lock_in_3,
   input logic open_lock_in_1,
   input logic open_lock_in_2,
   input logic open_lock_in_3,
   input logic ext_close_request_in,
   input logic close_cmd_out,
   input logic open_cmd_out,
   input bps_pos_t pos_code,
   input logic pos_closed,
   input logic pos_open,
   input logic pos_indeterminate,
   input logic pos_disturbed,
   input logic pos_not_closed,
   input logic single_contact_flag,
   input logic ready_flag,
   input logic removed_flag,
   input logic close_lock_flag,
   input logic open_lock_flag,
   input logic sup_cmd_success,
   input logic sup_cmd_trip_block,
   input logic sup_redundant_direction,
   input logic sup_not_ready
);
   logic cl_any;
   logic ol_any;
   assign cl_any = close_lock_in_1 | close_lock_in_2 | close_lock_in_3;
   assign ol_any = open_lock_in_1 | open_lock_in_2 | open_lock_in_3;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // idle request, long after the reset copy let go
   sequence s_req;
      $rose(ext_close_request_in) && !close_cmd_out && !open_cmd_out && $past(rst_n, 4);
   endsequence
   // ==========================================
   // position
   property p_flags;
      pos_closed == (pos_code == POS_CLOSED) && pos_open == (pos_code == POS_OPEN)
      && pos_indeterminate == (pos_code == POS_INDET)
      && pos_disturbed == (pos_code == POS_DISTURB) && pos_not_closed == !pos_closed;
   endproperty
   a_flags: assert property (p_flags) else $error("flags disagree with code");
   property p_decode;
      $past(rst_n, 4) && $past(closed_contact_in) != $past(open_contact_in)
      |-> pos_code == ($past(closed_contact_in) ? POS_CLOSED : POS_OPEN);
   endproperty
   a_decode: assert property (p_decode) else $error("contact decode wrong");
   property p_single;
      single_contact_flag && $past(single_contact_flag, 2) |-> !pos_indeterminate && !pos_disturbed;
   endproperty
   a_single: assert property (p_single) else $error("undetectable position shown");
   // disturbed only once a contradiction has lasted a while
   property p_dist;
      $rose(pos_disturbed) |-> $past(closed_contact_in, 5) && $past(open_contact_in, 5);
   endproperty
   a_dist: assert property (p_dist) else $error("disturbed too early");
   // ==========================================
   // level flags
   property p_locks;
      $past(rst_n, 4) |-> close_lock_flag == $past(cl_any) && open_lock_flag == $past(ol_any);
   endproperty
   a_locks: assert property (p_locks) else $error("interlock flag wrong");
   property p_ready;
      $past(rst_n, 4) |-> ready_flag == $past(breaker_ready_in)
      && removed_flag == $past(breaker_removed_in);
   endproperty
   a_ready: assert property (p_ready) else $error("ready or removed flag wrong");
   // ==========================================
   // command supervision
   property p_success;
      sup_cmd_success |-> $past(close_cmd_out) && pos_closed || $past(open_cmd_out) && pos_open;
   endproperty
   a_success: assert property (p_success) else $error("success without position");
   property p_trip;
      s_req ##0 trip_pending_in |-> ##1 sup_cmd_trip_block && !close_cmd_out;
   endproperty
   a_trip: assert property (p_trip) else $error("trip refusal missing");
   property p_nready;
      s_req ##0 !trip_pending_in && !breaker_ready_in |-> ##1 sup_not_ready && !close_cmd_out;
   endproperty
   a_nready: assert property (p_nready) else $error("not ready flag missing");
   property p_redund;
      s_req ##0 !trip_pending_in && breaker_ready_in && pos_closed |-> ##1 sup_redundant_direction;
   endproperty
   a_redund: assert property (p_redund) else $error("direction flag missing");
   property p_lock;
      $rose(close_cmd_out) |-> !$past(cl_any);
   endproperty
   a_lock: assert property (p_lock) else $error("close issued while locked");
endmodule
bind bps_top bps_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);

// >>> test/testbench.sv
// self-checking bench for the breaker supervision block
// assumes the breaker model on the contacts and a ten-cycle timer tick
`timescale 1ns/1ns
module testbench;
   import bps_pkg::*;
   logic clock, rst_n, hsel, hwrite, ready, removed, trip, creq, oreq, stuck, set_en, clr;
   logic [1:0] htrans, set_val;
   logic [2:0] hsize, cl, ol;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic hreadyout, hresp, close_cmd, open_cmd, cc, oc, irq;
   bps_pos_t pos_code;
   logic [9:0] fl;
   logic [5:0] sups, evs;
   int checks = 0;
   int bad_count = 0;
   // contacts, ready, removed, close locks, open locks, expected code
   logic [11:0] rows [5] = '{12'hA22, 12'h651, 12'h188, 12'h906, 12'h601};
   logic [7:0] ra [5] = '{OFS_CTRL, OFS_MOVE, OFS_DIST, OFS_MASK, 8'h20};
   logic [31:0] rv [5] = '{32'h0, 32'h0000000A, 32'h0000000A, 32'h0, 32'h0};
   bps_top #(.TICK_CYCLES(10)) uut (.clock(clock), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .closed_contact_in(cc), .open_contact_in(oc), .breaker_ready_in(ready),
      .breaker_removed_in(removed), .trip_pending_in(trip), .close_lock_in_1(cl[0]),
      .close_lock_in_2(cl[1]), .close_lock_in_3(cl[2]), .open_lock_in_1(ol[0]),
      .open_lock_in_2(ol[1]), .open_lock_in_3(ol[2]), .ext_close_request_in(creq),
      .ext_open_request_in(oreq), .close_cmd_out(close_cmd), .open_cmd_out(open_cmd),
      .pos_code(pos_code), .pos_closed(fl[9]), .pos_open(fl[8]), .pos_indeterminate(fl[7]),
      .pos_disturbed(fl[6]), .pos_not_closed(fl[5]), .single_contact_flag(fl[4]),
      .ready_flag(fl[3]), .removed_flag(fl[2]), .close_lock_flag(fl[1]),
      .open_lock_flag(fl[0]), .sup_cmd_success(sups[EV_SUCCESS]),
      .sup_cmd_disturbed(sups[EV_DISTURB]), .sup_cmd_trip_block(sups[EV_TRIP]),
      .sup_redundant_direction(sups[EV_REDUND]), .sup_close_during_open(sups[EV_CDO]),
      .sup_not_ready(sups[EV_NREADY]), .irq(irq));
   bps_breaker_model u_brk (.clock(clock), .close_cmd(close_cmd), .open_cmd(open_cmd),
      .stuck(stuck), .set_en(set_en), .set_val(set_val), .closed_contact(cc),
      .open_contact(oc));
   // ==========================================
   // helpers
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // pulses gathered since the last request
   always @(posedge clock) evs <= clr ? 6'h00 : (evs | sups);
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic hang;
      bad_count++;
      conclude();
   endtask
   task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
      checks++;
      if (seen_v !== exp_v) begin
         $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
         bad_count++;
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) hang();
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      r = hrdata;
   endtask
   task automatic contacts(input logic [1:0] v);
      set_val <= v;
      set_en <= 1'b1;
      @(posedge clock);
      set_en <= 1'b0;
   endtask
   // short limits mean a refusal that must stay silent
   task automatic cmd(input logic close, input int lim);
      int n = 0;
      clr <= 1'b1;
      if (close) creq <= 1'b1;
      else oreq <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      do begin
         @(posedge clock);
         n++;
      end while (n < lim && evs === 6'h00);
      if (n == lim && lim > 10) hang();
      creq <= 1'b0;
      oreq <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   // ==========================================
   // main sequence
   initial begin
      {rst_n, hsel, hwrite, ready, removed, trip, creq, oreq, stuck, set_en, clr} = 11'h000;
      {htrans, set_val, cl, ol, haddr, hwdata} = '0;
      hsize = 3'h2;
      repeat (4) @(posedge clock);
      chk({18'h0, hresp, hreadyout, pos_code, fl}, 32'h000000A0);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      foreach (ra[i]) begin
         ahb(1'b0, ra[i], 32'h0, rd);
         chk(rd, rv[i]);
      end
      foreach (rows[i]) begin
         {ready, removed, cl, ol} <= rows[i][9:2];
         contacts(rows[i][11:10]);
         repeat (3) @(posedge clock);
         chk({20'h0, pos_code, fl}, {20'h0, rows[i][1:0],
            rows[i][1:0] == POS_CLOSED, rows[i][1:0] == POS_OPEN, rows[i][1:0] == POS_INDET,
            rows[i][1:0] == POS_DISTURB, rows[i][1:0] != POS_CLOSED, 1'b0, rows[i][9:8],
            |rows[i][7:5], |rows[i][4:2]});
      end
      cmd(1'b1, 300);
      chk({24'h0, evs, pos_code}, {24'h0, 6'h01, POS_CLOSED});
      cmd(1'b1, 20);
      chk({26'h0, evs}, 32'h1 << EV_REDUND);
      ready <= 1'b0;
      cmd(1'b1, 20);
      chk({26'h0, evs}, 32'h1 << EV_NREADY);
      ready <= 1'b1;
      trip <= 1'b1;
      cmd(1'b1, 20);
      chk({26'h0, evs}, 32'h1 << EV_TRIP);
      trip <= 1'b0;
      stuck <= 1'b1;
      oreq <= 1'b1;
      repeat (3) @(posedge clock);
      cmd(1'b1, 20);
      chk({25'h0, open_cmd, evs}, 32'h40 | 32'h1 << EV_CDO);
      stuck <= 1'b0;
      repeat (20) @(posedge clock);
      chk({30'h0, pos_code}, {30'h0, POS_OPEN});
      cl <= 3'h4;
      cmd(1'b1, 10);
      chk({23'h0, close_cmd, pos_code, evs}, {23'h0, 1'b0, POS_OPEN, 6'h00});
      cl <= 3'h0;
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, OFS_MASK, 32'h1 << EV_TRIP, rd);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h1);
      ahb(1'b0, OFS_EVENT, 32'h0, rd);
      chk(rd, 32'h0000003D);
      repeat (2) @(posedge clock);
      ahb(1'b0, OFS_EVENT, 32'h0, rd);
      chk({30'h0, irq, |rd}, 32'h0);
      ahb(1'b1, OFS_CTRL, 32'h1, rd);
      contacts(2'h3);
      repeat (5) @(posedge clock);
      chk({27'h0, fl[4], fl[7], fl[6], pos_code}, {27'h0, 3'b100, POS_CLOSED});
      contacts(2'h0);
      repeat (3) @(posedge clock);
      chk({30'h0, pos_code}, {30'h0, POS_OPEN});
      ahb(1'b1, OFS_CTRL, 32'h0, rd);
      ahb(1'b1, OFS_MOVE, 32'h00000032, rd);
      stuck <= 1'b1;
      contacts(2'h3);
      repeat (3) @(posedge clock);
      chk({30'h0, pos_code}, {30'h0, POS_INDET});
      cmd(1'b1, 300);
      chk({26'h0, evs}, 32'h1 << EV_DISTURB);
      ahb(1'b0, OFS_STAT, 32'h0, rd);
      chk(rd & 32'h00000023, 32'h00000023);
      conclude();
   end
endmodule
